// *** verilog/barq_map.svh ***
`ifndef BARQ_MAP_SVH
`define BARQ_MAP_SVH
// reset timing, in native units and derived counts at 20 ns per cycle
`define BARQ_CLK_PERIOD_NS      20
`define BARQ_RST_PWR_US         1000
`define BARQ_RST_CLK_US         100
`define BARQ_RST_PWR_CYC        ((`BARQ_RST_PWR_US * 1000 + `BARQ_CLK_PERIOD_NS - 1) / `BARQ_CLK_PERIOD_NS)
`define BARQ_RST_CLK_CYC        ((`BARQ_RST_CLK_US * 1000 + `BARQ_CLK_PERIOD_NS - 1) / `BARQ_CLK_PERIOD_NS)
`define BARQ_FIRST_FRAME_CLKS   5
`define BARQ_SIG_QUIET_CLKS     4
`endif

// *** verilog/barq_pkg.sv ***
package barq_pkg;
    typedef enum logic [1:0] {
        BARQ_ST_RESET = 2'b00,
        BARQ_ST_WAIT  = 2'b01,
        BARQ_ST_IDLE  = 2'b10,
        BARQ_ST_RUN   = 2'b11
    } barq_state_e;
    // bus control sampled from pins, active high after inversion
    typedef struct packed {
        logic frame;
        logic irdy;
        logic idsel;
        logic pme;
        logic serr;
    } barq_ctl_s;
endpackage : barq_pkg

// *** verilog/barq_sync3.sv ***
`timescale 1ns/1ps
// three-stage input synchroniser; a change counts once stages two and three agree
module barq_sync3 #(
    parameter int W = 1
) (
    // clock and reset
    input  wire logic         ref_clk,
    input  wire logic         rst_n,
    // data
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    logic [W-1:0] s1, s2, s3;
    logic [W-1:0] next_q;
    always_comb begin
        for (int i = 0; i < W; i++) begin
            next_q[i] = (s2[i] == s3[i]) ? s3[i] : q[i];
        end
    end
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            s1 <= '1;
            s2 <= '1;
            s3 <= '1;
            q  <= '1;
        end else begin
            s1 <= d;
            s2 <= s1;
            s3 <= s2;
            q  <= next_q;
        end
    end
endmodule : barq_sync3

// *** verilog/barq_top.sv ***
`timescale 1ns/1ps
`include "barq_map.svh"
// Summary of operation
// R01 - sample bus inputs only on qualified edges
// R02 - ignore AD, byte enables, parity at turnaround
// R03 - idsel honoured only in configuration cycles
// R04 - ignore pme/serr for cycles after deassertion
// R05 - ignore inputs during and after reset
// R06 - reset accepted asynchronously, release may be synchronous
// R07 - outputs float at once on reset
// R08 - reset counts after power and clock times
// R09 - generator asserts reset on power-up, failure
// R10 - generator asserts reset early in power-up
// R11 - 500 mV rail fault: reset within 500 ns
// R12 - 5V below 3.3V: reset within 100 ns
// R13 - in-spec reset lasts minimum pulse width
// R14 - first release waits power-valid-to-release time
// R15 - bus idle five clocks before first frame
// R16 - hold state machines until released, ready, idle
// R17 - reset-to-first-frame delay is five clocks
// R18 - reset held 1 ms after power stable
// R19 - reset held 100 us after clock stable
// R20 - 100 ms from supplies valid to release
// R21 - release passes two-stage synchroniser
// R22 - bus idle when frame and irdy deasserted
module barq_top
    import barq_pkg::*;
#(
    parameter int RST_PWR_CYC = `BARQ_RST_PWR_CYC,
    parameter int RST_CLK_CYC = `BARQ_RST_CLK_CYC,
    parameter int QUIET_CLKS  = `BARQ_SIG_QUIET_CLKS
) (
    // clock and bus reset
    input  wire logic ref_clk,
    input  wire logic nrst,
    // device status
    input  wire logic pwr_stable,
    input  wire logic clk_stable,
    input  wire logic core_ready,
    // bus control pins, active low except idsel, which is active high
    input  wire logic frame_n,
    input  wire logic irdy_n,
    input  wire logic pme_n,
    input  wire logic serr_n,
    input  wire logic idsel,
    // transaction phase from the protocol engine
    input  wire logic cfg_cycle,
    input  wire logic ad_turnaround,
    // qualified outputs
    output logic      bus_oe,
    output logic      dev_reset_done,
    output logic      sm_run,
    output logic      bus_idle,
    output logic      idsel_q,
    output logic      pme_q,
    output logic      serr_q,
    output logic      ad_sample_en
);
    logic        rs1, rs2;
    logic        rst_n;
    barq_ctl_s   pin_raw, pin_s;
    barq_state_e state, next_state;
    logic [31:0] pwr_cnt, next_pwr_cnt, clk_cnt, next_clk_cnt;
    logic [7:0]  pme_cnt, next_pme_cnt, serr_cnt, next_serr_cnt;
    logic        pme_old, serr_old;
    logic        next_bus_oe, next_done, next_run, next_idle;
    logic        next_idsel, next_pme, next_serr, next_ad;
    logic        qual;

    // async assert, two-flop release [R06] [R21]
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            rs1 <= 1'b0;
            rs2 <= 1'b0;
        end else begin
            rs1 <= 1'b1;
            rs2 <= rs1;
        end
    end
    assign rst_n = rs2;

    assign pin_raw = '{frame: ~frame_n, irdy: ~irdy_n, idsel: idsel, pme: ~pme_n, serr: ~serr_n};
    barq_sync3 #(.W($bits(barq_ctl_s))) u_sync (
        .ref_clk (ref_clk),
        .rst_n   (rst_n),
        .d       (pin_raw),
        .q       (pin_s)
    );

    // inputs qualify only once reset has fully ended [R01] [R05]
    assign qual = (state != BARQ_ST_RESET);

    always_comb begin
        next_pwr_cnt = pwr_stable ? ((pwr_cnt < RST_PWR_CYC) ? pwr_cnt + 32'd1 : pwr_cnt) : 32'd0;
        next_clk_cnt = clk_stable ? ((clk_cnt < RST_CLK_CYC) ? clk_cnt + 32'd1 : clk_cnt) : 32'd0;
        next_done    = (pwr_cnt >= RST_PWR_CYC) && (clk_cnt >= RST_CLK_CYC); // [R08]
        next_idle    = qual && !pin_s.frame && !pin_s.irdy; // [R22]
        next_state   = state;
        case (state)
            BARQ_ST_RESET: if (dev_reset_done) next_state = BARQ_ST_WAIT;
            BARQ_ST_WAIT:  if (core_ready) next_state = BARQ_ST_IDLE;
            BARQ_ST_IDLE:  if (!core_ready) next_state = BARQ_ST_WAIT;
                           else if (bus_idle) next_state = BARQ_ST_RUN; // [R16]
            BARQ_ST_RUN:   next_state = BARQ_ST_RUN;
            default:       next_state = BARQ_ST_RESET;
        endcase
        next_run     = (next_state == BARQ_ST_RUN); // [R16]
        next_bus_oe  = next_run;
        next_idsel   = next_run && cfg_cycle && pin_s.idsel; // [R03]
        next_ad      = next_run && !ad_turnaround; // [R02]
        // hold-off after deassertion guards against slow pull-up recovery [R04]
        next_pme_cnt  = (pme_old && !pin_s.pme) ? 8'(QUIET_CLKS) : ((pme_cnt != 8'd0) ? pme_cnt - 8'd1 : 8'd0);
        next_serr_cnt = (serr_old && !pin_s.serr) ? 8'(QUIET_CLKS) : ((serr_cnt != 8'd0) ? serr_cnt - 8'd1 : 8'd0);
        next_pme     = qual && pin_s.pme && (pme_cnt == 8'd0);
        next_serr    = qual && pin_s.serr && (serr_cnt == 8'd0);
    end

    // outputs float at once: bus_oe, sm_run, idsel_q and ad_sample_en cleared by the raw async reset [R07]
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            bus_oe       <= 1'b0;
            sm_run       <= 1'b0;
            idsel_q      <= 1'b0;
            ad_sample_en <= 1'b0;
        end else if (!rst_n) begin
            bus_oe       <= 1'b0;
            sm_run       <= 1'b0;
            idsel_q      <= 1'b0;
            ad_sample_en <= 1'b0;
        end else begin
            bus_oe       <= next_bus_oe;
            sm_run       <= next_run;
            idsel_q      <= next_idsel;
            ad_sample_en <= next_ad;
        end
    end

    // counters run while bus reset is held; done stays set through a reset until power or clock is no longer counted stable
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            state    <= BARQ_ST_RESET;
            bus_idle <= 1'b0;
            pme_q    <= 1'b0;
            serr_q   <= 1'b0;
            pme_old  <= 1'b0;
            serr_old <= 1'b0;
            pme_cnt  <= 8'd0;
            serr_cnt <= 8'd0;
        end else begin
            state    <= next_state;
            bus_idle <= next_idle;
            pme_q    <= next_pme;
            serr_q   <= next_serr;
            pme_old  <= pin_s.pme;
            serr_old <= pin_s.serr;
            pme_cnt  <= next_pme_cnt;
            serr_cnt <= next_serr_cnt;
        end
    end

    // timing of reset length is measured while nrst is low, so not reset by it
    always_ff @(posedge ref_clk) begin
        pwr_cnt        <= next_pwr_cnt;
        clk_cnt        <= next_clk_cnt;
        dev_reset_done <= next_done || (dev_reset_done && rst_n);
    end

    a_float_on_reset: assert property (@(posedge ref_clk) !nrst |-> !bus_oe) // [R07]
        else $error("bus outputs driven during reset");
    a_run_needs_idle: assert property (@(posedge ref_clk) disable iff (!rst_n)
        $rose(sm_run) |-> $past(bus_idle) && $past(core_ready)) // [R16]
        else $error("state machines left reset without idle bus");
    a_idsel_cfg_only: assert property (@(posedge ref_clk) disable iff (!rst_n)
        idsel_q |-> $past(cfg_cycle)) // [R03]
        else $error("idsel honoured outside configuration");
    a_ad_turnaround: assert property (@(posedge ref_clk) disable iff (!rst_n)
        ad_sample_en |-> !$past(ad_turnaround)) // [R02]
        else $error("ad sampled during turnaround");
    a_pme_quiet: assert property (@(posedge ref_clk) disable iff (!rst_n)
        $fell(pin_s.pme) |-> ##1 !pme_q [*4]) // [R04]
        else $error("pme seen in quiet period");
    a_serr_quiet: assert property (@(posedge ref_clk) disable iff (!rst_n)
        $fell(pin_s.serr) |-> ##1 !serr_q [*4]) // [R04]
        else $error("serr seen in quiet period");
    a_done_times: assert property (@(posedge ref_clk)
        $rose(dev_reset_done) |-> $past(pwr_cnt) >= RST_PWR_CYC && $past(clk_cnt) >= RST_CLK_CYC) // [R08]
        else $error("reset done too early");
    a_inputs_ignored: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (state == BARQ_ST_RESET) |=> !bus_idle && !pme_q) // [R05]
        else $error("inputs used while in reset");
endmodule : barq_top

// *** tb/barq_agent_model.sv ***
`timescale 1ns/1ps
// other agents on the bus; released lines sit at their pull-up level
module barq_agent_model (
    // clock and bus reset
    input  wire logic ref_clk,
    input  wire logic nrst,
    // requests from the bench
    input  wire logic busy,
    input  wire logic pme_req,
    input  wire logic serr_req,
    // bus control pins
    output logic      frame_n,
    output logic      irdy_n,
    output logic      pme_n,
    output logic      serr_n
);
    logic [2:0] idle_cnt;
    logic       go;
    assign go = busy && idle_cnt == 3'h5;
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            idle_cnt <= 3'h0;
            frame_n  <= 1'b1;
            irdy_n   <= 1'b1;
        end else begin
            idle_cnt <= (idle_cnt == 3'h5) ? idle_cnt : idle_cnt + 3'h1;
            frame_n  <= ~go;
            irdy_n   <= ~go;
        end
    end
    always_ff @(posedge ref_clk) begin
        pme_n  <= ~pme_req;
        serr_n <= ~serr_req;
    end
endmodule : barq_agent_model

// *** tb/tb_top.sv ***
`timescale 1ns/1ps
module tb_top;
    logic       ref_clk = 1'b0;
    logic       nrst, pwr_stable, clk_stable, core_ready, idsel, cfg_cycle, ad_turnaround;
    logic       busy, pme_req, serr_req, frame_n, irdy_n, pme_n, serr_n;
    logic       bus_oe, dev_reset_done, sm_run, bus_idle, idsel_q, pme_q, serr_q, ad_sample_en;
    logic [3:0] q [$];
    logic [3:0] e;
    int         fail_count = 0;
    int         comparisons = 0;
    int         seed = 32'h3805;
    event       look;
    wire  [7:0] outs = {bus_oe, dev_reset_done, sm_run, bus_idle, idsel_q, pme_q, serr_q, ad_sample_en};

    always #10 ref_clk = ~ref_clk;
    barq_top #(.RST_PWR_CYC(6), .RST_CLK_CYC(4), .QUIET_CLKS(4)) dut (.*);
    barq_agent_model agent (.ref_clk(ref_clk), .nrst(nrst), .busy(busy), .pme_req(pme_req),
        .serr_req(serr_req), .frame_n(frame_n), .irdy_n(irdy_n), .pme_n(pme_n), .serr_n(serr_n));

    task automatic note(input int sel, input logic exp);
        q.push_back({sel[2:0], exp});
        ->look;
    endtask : note
    always @(look) begin
        while (q.size() > 0) begin
            e = q.pop_front();
            comparisons++;
            if (outs[e[3:1]] !== e[0]) begin
                fail_count++;
                $display("wrong value at %0t: got %h expected %h", $time, outs[e[3:1]], e[0]);
            end
        end
    end
    task automatic cyc(input int n);
        repeat (n) @(negedge ref_clk);
    endtask : cyc
    task automatic wait_for(input int sel, input logic exp, input int max);
        for (int i = 0; i < max && outs[sel] !== exp; i++) cyc(1);
        note(sel, exp);
    endtask : wait_for
    task automatic test_done;
        #1;
        $display("comparisons %0d fail_count %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : test_done

    initial begin
        #40000;
        fail_count++;
        test_done();
    end
    initial begin
        // clock counted only once it is flagged stable, so it starts low
        {nrst, pwr_stable, clk_stable, core_ready, idsel, cfg_cycle, ad_turnaround} = 7'h00;
        {busy, pme_req, serr_req} = 3'h0;
        cyc(4);
        note(6, 1'b0);
        note(7, 1'b0);
        {pwr_stable, clk_stable} = 2'h3;
        cyc(2);
        note(6, 1'b0);
        wait_for(6, 1'b1, 10);
        nrst = 1'b1;
        busy = 1'b1;
        cyc(4);
        note(5, 1'b0);
        cyc(10);
        core_ready = 1'b1;
        cyc(10);
        note(4, 1'b0);
        note(5, 1'b0);
        busy = 1'b0;
        wait_for(4, 1'b1, 8);
        wait_for(5, 1'b1, 6);
        wait_for(7, 1'b1, 4);
        repeat (6) begin
            ad_turnaround = 1'($random(seed));
            idsel = 1'($random(seed));
            cyc(6);
            note(0, ~ad_turnaround);
            note(3, 1'b0);
        end
        {cfg_cycle, idsel, ad_turnaround} = 3'h6;
        wait_for(3, 1'b1, 8);
        {cfg_cycle, idsel} = 2'h0;
        for (int s = 1; s <= 2; s++) begin
            {pme_req, serr_req} = (s == 2) ? 2'h2 : 2'h1;
            wait_for(s, 1'b1, 8);
            {pme_req, serr_req} = 2'h0;
            cyc(2);
            // reassert inside the quiet window, long enough to pass the filter
            {pme_req, serr_req} = (s == 2) ? 2'h2 : 2'h1;
            cyc(2);
            {pme_req, serr_req} = 2'h0;
            cyc(4);
            note(s, 1'b0);
            cyc(1);
            note(s, 1'b0);
            cyc(6);
            note(s, 1'b0);
        end
        nrst = 1'b0;
        #1;
        note(7, 1'b0);
        note(5, 1'b0);
        cyc(8);
        nrst = 1'b1;
        cyc(2);
        note(5, 1'b0);
        wait_for(5, 1'b1, 12);
        // supply fault: reset follows well inside the shorter limit
        pwr_stable = 1'b0;
        #45;
        nrst = 1'b0;
        #1;
        note(7, 1'b0);
        cyc(3);
        note(6, 1'b0);
        test_done();
    end
endmodule : tb_top
